/* hw/cioc_edge.sv */
`default_nettype none
`include "cioc_params.svh"
module cioc_edge
  import cioc_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, low active
  input wire cioc_inputs_t raw, // Contact inputs
  output cioc_inputs_t level, // Sampled levels
  output cioc_inputs_t rise // One-cycle off-to-on events
);
  cioc_sync_t st_ff;
  cioc_sync_t nxt_st;

  always_comb
  begin
    nxt_st.cur = raw;
    nxt_st.prev = st_ff.cur;
  end

  always_ff @(posedge aclk)
  begin
    // Both stages load the pins, so a contact held on through reset makes no edge
    if (!aresetn)
    begin
      st_ff.prev <= raw;
      st_ff.cur <= raw;
    end
    else
      st_ff <= nxt_st;
  end

  assign level = st_ff.cur;
  assign rise = st_ff.cur & ~st_ff.prev;
endmodule : cioc_edge
`default_nettype wire

/* hw/cioc_top.sv */
`default_nettype none
`include "cioc_params.svh"
module cioc_top
  import cioc_pkg::*;
#(
  parameter int OUT_W = 16,
  parameter int PAT_W = 9
)
(
  input wire logic aclk, // Clock, 100 MHz
  input wire logic aresetn, // Sync reset, low active
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read valid
  input wire logic s_axi_rready, // Read ready
  input wire cioc_inputs_t contacts, // Contact inputs
  input wire cioc_events_t events, // PV, alarm and time event sources
  output logic [6:0] event_out, // Base contact outputs
  output logic [7:0] ext_mod1_out, // First extension module outputs
  output logic [7:0] ext_mod3_out, // Third extension module outputs
  output logic [OUT_W-1:0] ctrl_out_value, // Control output value
  output logic loop_supply_en, // Loop supply on shared terminal
  output logic retrans1_en, // Retransmission 1 active
  output logic retrans2_en, // Retransmission 2 on control terminal
  output logic [PAT_W-1:0] pattern_no, // Selected pattern number
  output cioc_mode_t mode, // Operating mode
  output logic auto_mode, // Automatic output mode
  output logic seg_advance, // One-cycle segment advance pulse
  output logic irq // Level interrupt
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic aw_free;
    logic w_free;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [OUT_W-1:0] manual_val;
    logic [OUT_W-1:0] preset_val;
    logic [OUT_W-1:0] out_val;
    logic [PAT_W-1:0] pattern;
    cioc_mode_t mode;
    logic auto_md;
    logic advance;
    logic [6:0] ev_out;
    logic [7:0] ext1;
    logic [7:0] ext3;
    logic loop_sup;
    logic retrans1_type;
    logic retrans2_type;
    logic irq;
    logic up_prev;
    logic dn_prev;
  } cioc_state_t;

  cioc_state_t s_ff;
  cioc_state_t nxt_s;
  cioc_inputs_t lvl;
  cioc_inputs_t rise;

  cioc_edge u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw(contacts),
    .level(lvl),
    .rise(rise)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction : merge

  logic ext_present;
  logic [3:0] retrans1_type_type;
  logic [3:0] retrans2_type_type;
  logic [PAT_W-1:0] sel_pattern;
  logic key_stop_rise;
  logic up_rise;
  logic dn_rise;
  logic [7:0] evt_set;

  assign ext_present = s_ff.ctrl[`CIOC_CTRL_EXT_PRESENT];
  assign retrans1_type_type = s_ff.ctrl[`CIOC_CTRL_RETRANS1_TYPE_LSB +: 4];
  assign retrans2_type_type = s_ff.ctrl[`CIOC_CTRL_RETRANS2_TYPE_LSB +: 4];
  assign up_rise = s_ff.ctrl[`CIOC_CTRL_KEY_UP] & ~s_ff.up_prev;
  assign dn_rise = s_ff.ctrl[`CIOC_CTRL_KEY_DOWN] & ~s_ff.dn_prev;

  // Extension weights only count when a module is fitted
  always_comb
  begin
    sel_pattern = PAT_W'(lvl.pattern_sel);
    if (ext_present)
      sel_pattern = sel_pattern + {lvl.ext_pattern_add256, lvl.ext_pattern_add128,
                                   lvl.ext_pattern_add64, lvl.ext_pattern_add32,
                                   lvl.ext_pattern_add16, 4'h0};
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.advance = 1'b0;
    nxt_s.up_prev = s_ff.ctrl[`CIOC_CTRL_KEY_UP];
    nxt_s.dn_prev = s_ff.ctrl[`CIOC_CTRL_KEY_DOWN];
    key_stop_rise = 1'b0;
    evt_set = '0;

    // AXI write: address and data taken in either order
    // Ready flags are kept as free flags so the ready outputs come straight from flops
    if (s_axi_awvalid && s_ff.aw_free)
    begin
      nxt_s.aw_free = 1'b0;
      nxt_s.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_ff.w_free)
    begin
      nxt_s.w_free = 1'b0;
      nxt_s.w_data = s_axi_wdata;
      nxt_s.w_strb = s_axi_wstrb;
    end
    if (!s_ff.aw_free && !s_ff.w_free && !s_ff.bvalid)
    begin
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = `CIOC_BRESP_OKAY;
      nxt_s.aw_free = 1'b1;
      nxt_s.w_free = 1'b1;
      case (s_ff.aw_addr)
        `CIOC_ADDR_CTRL:
        begin
          // Bits 18:16 keep one of eight PID groups for the loop
          nxt_s.ctrl = merge(s_ff.ctrl, s_ff.w_data, s_ff.w_strb);
          key_stop_rise = nxt_s.ctrl[`CIOC_CTRL_KEY_STOP] & ~s_ff.ctrl[`CIOC_CTRL_KEY_STOP];
          nxt_s.ctrl[`CIOC_CTRL_KEY_STOP] = 1'b0;
        end
        `CIOC_ADDR_IRQ_STAT:
          if (s_ff.w_strb[0])
            nxt_s.irq_stat = s_ff.irq_stat & ~s_ff.w_data[7:0];
        `CIOC_ADDR_IRQ_MASK:
          if (s_ff.w_strb[0])
            nxt_s.irq_mask = s_ff.w_data[7:0];
        `CIOC_ADDR_MANUAL:
          nxt_s.manual_val = OUT_W'(merge(32'(s_ff.manual_val), s_ff.w_data, s_ff.w_strb));
        `CIOC_ADDR_PRESET:
          nxt_s.preset_val = OUT_W'(merge(32'(s_ff.preset_val), s_ff.w_data, s_ff.w_strb));
        `CIOC_ADDR_STATUS, `CIOC_ADDR_EVENTS, `CIOC_ADDR_OUTPUT: ;
        default:
          nxt_s.bresp = `CIOC_BRESP_SLVERR;
      endcase
    end
    if (s_ff.bvalid && s_axi_bready)
      nxt_s.bvalid = 1'b0;

    // AXI read: one-cycle arready then rvalid
    nxt_s.arready = s_axi_arvalid && !s_ff.arready && !s_ff.rvalid;
    if (s_ff.arready)
    begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = `CIOC_BRESP_OKAY;
      case (s_axi_araddr[7:0])
        `CIOC_ADDR_CTRL: nxt_s.rdata = s_ff.ctrl;
        `CIOC_ADDR_STATUS: nxt_s.rdata = {11'h000, s_ff.auto_md, 1'b0, s_ff.mode,
                                          7'h00, s_ff.pattern};
        `CIOC_ADDR_IRQ_STAT: nxt_s.rdata = {24'h000000, s_ff.irq_stat};
        `CIOC_ADDR_IRQ_MASK: nxt_s.rdata = {24'h000000, s_ff.irq_mask};
        `CIOC_ADDR_EVENTS: nxt_s.rdata = {9'h000, s_ff.ext3, s_ff.ext1, s_ff.ev_out};
        `CIOC_ADDR_MANUAL: nxt_s.rdata = 32'(s_ff.manual_val);
        `CIOC_ADDR_PRESET: nxt_s.rdata = 32'(s_ff.preset_val);
        `CIOC_ADDR_OUTPUT: nxt_s.rdata = 32'(s_ff.out_val);
        default:
        begin
          nxt_s.rdata = 32'h00000000;
          nxt_s.rresp = `CIOC_BRESP_SLVERR;
        end
      endcase
    end
    if (s_ff.rvalid && s_axi_rready)
      nxt_s.rvalid = 1'b0;

    // ----------------------------------------------------------------
    // Operating mode; stop wins when both edges arrive together
    // ----------------------------------------------------------------
    if (rise.run_stop_in || key_stop_rise)
    begin
      nxt_s.mode = CIOC_RESET_MODE;
      evt_set[1] = 1'b1;
    end
    else if (rise.local_mode_in)
    begin
      nxt_s.mode = CIOC_LOCAL;
      evt_set[2] = 1'b1;
    end
    else if (rise.run_start_in)
    begin
      nxt_s.mode = CIOC_RUN;
      evt_set[0] = 1'b1;
    end
    else if (ext_present && rise.ext_hold_in && s_ff.mode == CIOC_RUN)
    begin
      nxt_s.mode = CIOC_HOLD;
      evt_set[3] = 1'b1;
    end
    if (ext_present && rise.ext_advance_in &&
        (s_ff.mode == CIOC_RUN || s_ff.mode == CIOC_HOLD))
    begin
      nxt_s.advance = 1'b1;
      evt_set[4] = 1'b1;
    end

    // Pattern tracked only in reset mode; zero or above CIOC_PATTERN_MAX selects the default pattern
    if (s_ff.mode == CIOC_RESET_MODE && !rise.run_start_in)
    begin
      if (sel_pattern > `CIOC_PATTERN_MAX || sel_pattern == '0)
        nxt_s.pattern = `CIOC_PATTERN_DEF;
      else
        nxt_s.pattern = sel_pattern;
      if (nxt_s.pattern != s_ff.pattern)
        evt_set[5] = 1'b1;
    end

    // Auto/manual is a level; without a module the block stays automatic
    nxt_s.auto_md = ext_present ? lvl.ext_auto_manual_in : 1'b1;
    if (ext_present && s_ff.auto_md != nxt_s.auto_md)
      evt_set[6] = 1'b1;
    if (!s_ff.auto_md)
    begin
      if (up_rise && s_ff.manual_val != '1)
        nxt_s.manual_val = s_ff.manual_val + 1'b1;
      else if (dn_rise && s_ff.manual_val != '0)
        nxt_s.manual_val = s_ff.manual_val - 1'b1;
    end

    // Preset dominates manual whenever stopped
    if (s_ff.mode == CIOC_RESET_MODE)
      nxt_s.out_val = s_ff.preset_val;
    else if (!s_ff.auto_md)
      nxt_s.out_val = s_ff.manual_val;
    else
      nxt_s.out_val = s_ff.out_val;

    // Contact output mapping
    nxt_s.ev_out = {events.time_event[3:0], events.instr_alarm1,
                    events.pv_event[1:0]};
    nxt_s.ext1 = ext_present ? {events.time_event[9:4], events.pv_event[3:2]} : 8'h00;
    nxt_s.ext3 = ext_present ? {events.time_event[15:10], events.pv_event[5:4]} : 8'h00;
    evt_set[7] = |(nxt_s.ev_out & ~s_ff.ev_out);

    // Shared terminals
    nxt_s.loop_sup = (retrans1_type_type == `CIOC_LOOP_SUPPLY_TYPE) ||
                     (retrans2_type_type == `CIOC_LOOP_SUPPLY_TYPE);
    nxt_s.retrans1_type = (retrans1_type_type != 4'h0) && (retrans1_type_type != `CIOC_LOOP_SUPPLY_TYPE);
    nxt_s.retrans2_type = (retrans2_type_type != 4'h0) && (retrans2_type_type != `CIOC_LOOP_SUPPLY_TYPE) &&
                 s_ff.ctrl[`CIOC_CTRL_CTRL1_RELAY];

    // Sticky status: a set beats a clear in the same cycle
    nxt_s.irq_stat = nxt_s.irq_stat | evt_set;
    nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_ff <= '0;
      s_ff.mode <= CIOC_RESET_MODE;
      s_ff.auto_md <= 1'b1;
      s_ff.pattern <= `CIOC_PATTERN_DEF;
      s_ff.out_val <= `CIOC_OUT_RESET;
      s_ff.aw_free <= 1'b1;
      s_ff.w_free <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = s_ff.aw_free;
  assign s_axi_wready = s_ff.w_free;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_arready = s_ff.arready;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rdata = s_ff.rdata;
  assign s_axi_rresp = s_ff.rresp;
  assign event_out = s_ff.ev_out;
  assign ext_mod1_out = s_ff.ext1;
  assign ext_mod3_out = s_ff.ext3;
  assign ctrl_out_value = s_ff.out_val;
  assign loop_supply_en = s_ff.loop_sup;
  assign retrans1_en = s_ff.retrans1_type;
  assign retrans2_en = s_ff.retrans2_type;
  assign pattern_no = s_ff.pattern;
  assign mode = s_ff.mode;
  assign auto_mode = s_ff.auto_md;
  assign seg_advance = s_ff.advance;
  assign irq = s_ff.irq;
endmodule : cioc_top
`default_nettype wire

/* include/cioc_params.svh */
`ifndef CIOC_PARAMS_SVH
`define CIOC_PARAMS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define CIOC_ADDR_CTRL 8'h00
`define CIOC_ADDR_STATUS 8'h04
`define CIOC_ADDR_IRQ_STAT 8'h08
`define CIOC_ADDR_IRQ_MASK 8'h0C
`define CIOC_ADDR_EVENTS 8'h10
`define CIOC_ADDR_MANUAL 8'h14
`define CIOC_ADDR_PRESET 8'h18
`define CIOC_ADDR_OUTPUT 8'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CIOC_CTRL_EXT_PRESENT 0
`define CIOC_CTRL_KEY_STOP 1
`define CIOC_CTRL_KEY_UP 2
`define CIOC_CTRL_KEY_DOWN 3
`define CIOC_CTRL_CTRL1_RELAY 4
`define CIOC_CTRL_RETRANS1_TYPE_LSB 8
`define CIOC_CTRL_RETRANS2_TYPE_LSB 12
`define CIOC_CTRL_PID_LSB 16
`define CIOC_LOOP_SUPPLY_TYPE 4'h4
`define CIOC_PATTERN_MAX 9'h12C
`define CIOC_PATTERN_DEF 9'h001
`define CIOC_OUT_RESET 16'h0000
`define CIOC_BRESP_OKAY 2'h0
`define CIOC_BRESP_SLVERR 2'h2
`define CIOC_NUM_INPUTS 15
`define CIOC_NUM_EVT 8

`endif

/* include/cioc_pkg.sv */
`default_nettype none
package cioc_pkg;
  typedef enum logic [2:0] {
    CIOC_RESET_MODE = 3'h0,
    CIOC_RUN = 3'h1,
    CIOC_HOLD = 3'h2,
    CIOC_LOCAL = 3'h3
  } cioc_mode_t;

  typedef struct packed {
    logic ext_pattern_add256;
    logic ext_pattern_add128;
    logic ext_pattern_add64;
    logic ext_pattern_add32;
    logic ext_pattern_add16;
    logic ext_auto_manual_in;
    logic ext_advance_in;
    logic ext_hold_in;
    logic local_mode_in;
    logic run_stop_in;
    logic run_start_in;
    logic [3:0] pattern_sel;
  } cioc_inputs_t;

  typedef struct packed {
    logic [5:0] pv_event;
    logic instr_alarm1;
    logic [15:0] time_event;
  } cioc_events_t;

  typedef struct packed {
    cioc_inputs_t prev;
    cioc_inputs_t cur;
  } cioc_sync_t;
endpackage : cioc_pkg
`default_nettype wire

/* verification/cioc_switch_model.sv */
`default_nettype none
module cioc_switch_model
  import cioc_pkg::*;
(
  input wire logic aclk, // Clock
  input wire cioc_inputs_t want, // Switch positions set by the bench
  input wire cioc_events_t src, // Event levels set by the bench
  output cioc_inputs_t contacts, // Contact levels at the device
  output cioc_events_t events // Event levels at the device
);
  // Levers settle one cycle after they move; bounce is left out
  always_ff @(posedge aclk)
  begin
    contacts <= want;
    events <= src;
  end
endmodule : cioc_switch_model
`default_nettype wire

/* verification/cioc_top_asserts.sv */
`default_nettype none
module cioc_top_asserts
  import cioc_pkg::*;
#(
  parameter int OUT_W = 16,
  parameter int PAT_W = 9
)
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, low active
  input wire cioc_inputs_t contacts, // Contact inputs
  input wire cioc_events_t events, // Event sources
  input wire logic [6:0] event_out, // Base outputs
  input wire logic [7:0] ext_mod1_out, // First module outputs
  input wire cioc_mode_t mode, // Operating mode
  input wire logic seg_advance, // Advance pulse
  input wire logic [PAT_W-1:0] pattern_no // Pattern number
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----
  // Mapping
  // ----
  // First edge after reset still shows cleared outputs
  a_base_out_map: assert property ($past(aresetn) |->
    event_out == $past({events.time_event[3:0], events.instr_alarm1, events.pv_event[1:0]}))
    else $error("base output mapping wrong");
  a_ext_out_map: assert property (ext_mod1_out != 8'h00 |->
    ext_mod1_out == $past({events.time_event[9:4], events.pv_event[3:2]}))
    else $error("extension output mapping wrong");
  // ----
  // Modes
  // ----
  a_start_runs: assert property ($rose(contacts.run_start_in) && !contacts.run_stop_in
    && !contacts.local_mode_in && mode == CIOC_RESET_MODE |-> ##2 mode == CIOC_RUN)
    else $error("start did not run");
  a_stop_resets: assert property ($rose(contacts.run_stop_in) |->
    ##2 mode == CIOC_RESET_MODE)
    else $error("stop did not halt");
  a_local_enters: assert property ($rose(contacts.local_mode_in) && !contacts.run_stop_in
    |-> ##2 mode == CIOC_LOCAL)
    else $error("local mode not entered");
  a_adv_pulse: assert property (seg_advance |->
    (mode == CIOC_RUN || mode == CIOC_HOLD) ##1 !seg_advance)
    else $error("advance pulse wrong");
  a_pat_range: assert property (pattern_no != 9'h000 && pattern_no <= 9'h12C)
    else $error("pattern out of range");
  a_pat_frozen: assert property (mode != CIOC_RESET_MODE && $past(mode) != CIOC_RESET_MODE
    |-> $stable(pattern_no))
    else $error("pattern changed while running");
  c_run: cover property (mode == CIOC_RUN);
  c_hold: cover property (mode == CIOC_HOLD);
  c_adv: cover property (seg_advance);
endmodule : cioc_top_asserts

bind cioc_top cioc_top_asserts #(.OUT_W(OUT_W), .PAT_W(PAT_W)) i_cioc_top_asserts (
  .aclk(aclk), .aresetn(aresetn), .contacts(contacts), .events(events),
  .event_out(event_out), .ext_mod1_out(ext_mod1_out), .mode(mode),
  .seg_advance(seg_advance), .pattern_no(pattern_no)
);
`default_nettype wire

/* verification/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cioc_pkg::*;
`define CHK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
  logic aclk = 1'h0;
  logic aresetn;
  logic [31:0] awaddr, wdata, araddr, rdata, d, r32;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [3:0] wstrb;
  cioc_inputs_t want, contacts;
  cioc_events_t ev_want, events, e;
  logic [6:0] event_out;
  logic [7:0] m1, m3;
  logic [15:0] ctrl_out;
  logic loop_en, r1_en, r2_en, auto_mode, seg_advance, irq;
  logic [8:0] pattern_no;
  cioc_mode_t mode;
  int fail_count = 0;
  int n_tests = 0;
  int adv_cnt = 0;
  int pats[$] = '{0, 17, 300, 301, 5};

  always #5 aclk = ~aclk;
  always @(posedge aclk)
    if (seg_advance === 1'h1)
      adv_cnt <= adv_cnt + 1;

  cioc_top i_cioc_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .contacts(contacts), .events(events), .event_out(event_out), .ext_mod1_out(m1),
    .ext_mod3_out(m3), .ctrl_out_value(ctrl_out), .loop_supply_en(loop_en),
    .retrans1_en(r1_en), .retrans2_en(r2_en), .pattern_no(pattern_no), .mode(mode),
    .auto_mode(auto_mode), .seg_advance(seg_advance), .irq(irq)
  );
  cioc_switch_model i_cioc_switch_model (
    .aclk(aclk), .want(want), .src(ev_want), .contacts(contacts), .events(events)
  );

  function automatic logic [8:0] exp_pat(input int p);
    return (p == 0 || p > 300) ? 9'h001 : 9'(p);
  endfunction : exp_pat

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= {24'h000000, a};
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1);
    bready <= 1'h0;
    `CHK(bresp, 2'h0)
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= {24'h000000, a};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'h0;
    end
    while (rvalid !== 1'h1);
    v = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask : rd

  // Long enough for the edge to pass both sampling stages and the mode update
  task automatic tog(input int b);
    want[b] <= 1'h1;
    repeat (5) @(posedge aclk);
    want[b] <= 1'h0;
    repeat (5) @(posedge aclk);
  endtask : tog

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    test_done();
  end

  initial
  begin
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 32'h0;
    wdata = 32'h0;
    araddr = 32'h0;
    wstrb = 4'hF;
    want = '0;
    want.ext_auto_manual_in = 1'h1;
    ev_want = '0;
    r32 = $urandom(32'hDE24);
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    `CHK({mode, pattern_no}, {CIOC_RESET_MODE, 9'h001})
    // ----
    // Terminal sharing
    // ----
    wr(8'h00, 32'h0000_1401);
    repeat (3) @(posedge aclk);
    `CHK({loop_en, r1_en, r2_en}, 3'h4)
    wr(8'h00, 32'h0000_3211);
    repeat (3) @(posedge aclk);
    `CHK({loop_en, r1_en, r2_en}, 3'h3)
    rd(8'h40, d, r);
    `CHK({r, d}, {2'h2, 32'h0})
    // ----
    // Outputs and pattern select
    // ----
    repeat (8)
    begin
      r32 = $urandom;
      ev_want <= r32[22:0];
      repeat (3) @(posedge aclk);
      e = r32[22:0];
      `CHK(event_out, {e.time_event[3:0], e.instr_alarm1, e.pv_event[1:0]})
      `CHK({m3, m1}, {e.time_event[15:10], e.pv_event[5:4], e.time_event[9:4], e.pv_event[3:2]})
    end
    repeat (6) pats.push_front($urandom % 512);
    foreach (pats[i])
    begin
      want[3:0] <= pats[i][3:0];
      want[14:10] <= pats[i][8:4];
      repeat (6) @(posedge aclk);
      `CHK(pattern_no, exp_pat(pats[i]))
      rd(8'h04, d, r);
      `CHK(d[8:0], exp_pat(pats[i]))
    end
    // ----
    // Mode sequence
    // ----
    wr(8'h18, 32'h0000_1234);
    wr(8'h14, 32'h0000_0055);
    wr(8'h0C, 32'h0000_0001);
    tog(4);
    `CHK({mode, irq, pattern_no}, {CIOC_RUN, 1'h1, 9'h005})
    want[3:0] <= 4'h9;
    repeat (6) @(posedge aclk);
    `CHK(pattern_no, 9'h005)
    wr(8'h08, 32'h0000_00FF);
    tog(7);
    `CHK({mode, irq}, {CIOC_HOLD, 1'h0})
    tog(8);
    `CHK(adv_cnt, 1)
    want.ext_auto_manual_in <= 1'h0;
    repeat (6) @(posedge aclk);
    `CHK({auto_mode, ctrl_out}, {1'h0, 16'h0055})
    wr(8'h00, 32'h0000_3215);
    repeat (3) @(posedge aclk);
    `CHK(ctrl_out, 16'h0056)
    tog(5);
    `CHK({mode, ctrl_out}, {CIOC_RESET_MODE, 16'h1234})
    want.ext_auto_manual_in <= 1'h1;
    repeat (6) @(posedge aclk);
    `CHK(auto_mode, 1'h1)
    tog(6);
    `CHK(mode, CIOC_LOCAL)
    // Software stop and down key in manual, PID group kept in control word
    want.ext_auto_manual_in <= 1'h0;
    repeat (6) @(posedge aclk);
    wr(8'h00, 32'h0007_321B);
    `CHK(mode, CIOC_RESET_MODE)
    rd(8'h00, d, r);
    `CHK(d, 32'h0007_3219)
    rd(8'h14, d, r);
    `CHK(d, 32'h0000_0055)
    test_done();
  end
endmodule : tb
`default_nettype wire
